// >>> design/dvs_cfg.svh
// Constants of the playback volume, soft mute and bass boost block
`ifndef DVS_CFG_SVH
`define DVS_CFG_SVH
// ****************************************************************
// Register map (byte addresses)
// ****************************************************************
`define DVS_OFS_CTRL      8'h00
`define DVS_OFS_VOL       8'h04
`define DVS_OFS_STATUS    8'h08
// CTRL fields
`define DVS_CTRL_MUTE     0
`define DVS_CTRL_RSEL     1
`define DVS_CTRL_LINK     2
`define DVS_CTRL_BST_LO   4
`define DVS_CTRL_BST_HI   5
// VOL fields
`define DVS_VOL_L_LO      0
`define DVS_VOL_L_HI      7
`define DVS_VOL_R_LO      8
`define DVS_VOL_R_HI      15
// STATUS fields
`define DVS_ST_LL_HI      10
`define DVS_ST_RL_LO      16
`define DVS_ST_RL_HI      26
`define DVS_ST_RAMP       31
// Reset values
`define DVS_RST_CODE      8'h18
`define DVS_RST_BOOST     2'h0
// ****************************************************************
// Volume ramp
// ****************************************************************
`define DVS_CODE_MUTE     8'hFF
`define DVS_CODE_SHIFT    2
`define DVS_LVL_MAX       11'h425
`define DVS_LVL_UNITY     11'h060
`define DVS_STEP_SLOW     11'h001
`define DVS_STEP_FAST     11'h004
`define DVS_STEP_FASTX    11'h005
`define DVS_FAST_EXTRA    8'h25
// ****************************************************************
// Gain and filter arithmetic
// ****************************************************************
`define DVS_OCT_LEVELS    11'h030
`define DVS_MANT_ONE      17'h10000
`define DVS_MANT_SLOPE    17'h002AB
`define DVS_GAIN_SHIFT    14
`define DVS_LP_SHIFT      5
`define DVS_SMAX          42'sh000007FFFFF
`define DVS_SMIN          42'sh3FFFF800000
`define DVS_RESP_OKAY     2'h0
`define DVS_RESP_SLVERR   2'h2
`endif

// >>> design/dvs_pkg.sv
// Types of the playback volume, soft mute and bass boost block
package dvs_pkg;
   typedef struct packed {
      logic [23:0] left;
      logic [23:0] right;
   } dvs_pair_t;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        aw_got;
      logic        w_got;
      logic [7:0]  awaddr;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic        soft_mute_request;
      logic        ramp_time_select;
      logic        volume_link;
      logic [1:0]  bass_boost_level;
      logic [7:0]  left_volume_code;
      logic [7:0]  right_volume_code;
      logic [10:0] lvl_l;
      logic [10:0] lvl_r;
      logic [7:0]  phase;
      logic [23:0] lp_l;
      logic [23:0] lp_r;
      logic        out_valid;
      dvs_pair_t   out_sample;
   } dvs_state_t;
endpackage

// >>> design/dvs_top.sv
// Playback path: bass boost, linked or split volume ramp, soft mute
`timescale 1ns/100ps
`default_nettype none
`include "dvs_cfg.svh"
module dvs_top
   import dvs_pkg::*;
(
   input  wire logic        aclk,          // 25 MHz clock
   input  wire logic        aresetn,       // Sync reset, active low
   input  wire logic [7:0]  s_axi_awaddr,  // Write address
   input  wire logic        s_axi_awvalid, // Write address valid
   output logic             s_axi_awready, // Write address ready
   input  wire logic [31:0] s_axi_wdata,   // Write data
   input  wire logic [3:0]  s_axi_wstrb,   // Write byte strobes
   input  wire logic        s_axi_wvalid,  // Write data valid
   output logic             s_axi_wready,  // Write data ready
   output logic [1:0]       s_axi_bresp,   // Write response
   output logic             s_axi_bvalid,  // Write response valid
   input  wire logic        s_axi_bready,  // Write response ready
   input  wire logic [7:0]  s_axi_araddr,  // Read address
   input  wire logic        s_axi_arvalid, // Read address valid
   output logic             s_axi_arready, // Read address ready
   output logic [31:0]      s_axi_rdata,   // Read data
   output logic [1:0]       s_axi_rresp,   // Read response
   output logic             s_axi_rvalid,  // Read data valid
   input  wire logic        s_axi_rready,  // Read data ready
   input  wire logic        in_valid,      // One pulse per sample period
   input  wire dvs_pair_t   in_sample,     // Signed stereo sample in
   output logic             out_valid,     // Processed sample strobe
   output dvs_pair_t        out_sample     // Processed sample to DAC
);
   // ****************************************************************
   // Arithmetic helpers
   // ****************************************************************
   function automatic logic [23:0] sat(input logic signed [41:0] v);
      if (v > `DVS_SMAX) begin
         sat = 24'h7FFFFF;
      end else if (v < `DVS_SMIN) begin
         sat = 24'h800000;
      end else begin
         sat = v[23:0];
      end
   endfunction

   function automatic logic [10:0] target(input logic [7:0] code,
                                          input logic       mute);
      if (mute || code == `DVS_CODE_MUTE) begin
         target = `DVS_LVL_MAX;
      end else begin
         target = 11'(code) << `DVS_CODE_SHIFT;
      end
   endfunction

   // Level 0 is 4.0 in Q14; each level is 1/8 dB, linear within an octave
   function automatic logic [16:0] gain_of(input logic [10:0] lvl);
      logic [4:0]  oct;
      logic [5:0]  frac;
      logic [16:0] m;
      oct  = 5'(lvl / `DVS_OCT_LEVELS);
      frac = 6'(lvl % `DVS_OCT_LEVELS);
      m    = `DVS_MANT_ONE - 17'(frac * `DVS_MANT_SLOPE);
      if (lvl >= `DVS_LVL_MAX) begin
         gain_of = 17'h00000;
      end else begin
         gain_of = m >> oct;
      end
   endfunction

   function automatic logic [10:0] ramp(input logic [10:0] cur,
                                        input logic [10:0] tgt,
                                        input logic [10:0] inc);
      if (cur < tgt) begin
         ramp = (tgt - cur > inc) ? 11'(cur + inc) : tgt;
      end else begin
         ramp = (cur - tgt > inc) ? 11'(cur - inc) : tgt;
      end
   endfunction

   // Low-pass feedback gives the low-frequency lift, then clips
   function automatic logic [23:0] boost(input logic [23:0] x,
                                         input logic [23:0] lp,
                                         input logic [1:0]  lvl);
      logic signed [41:0] xs;
      logic signed [41:0] ls;
      logic signed [41:0] add;
      xs = 42'($signed(x));
      ls = 42'($signed(lp));
      case (lvl)
         2'h1:    add = ls >>> 1;
         2'h2:    add = ls;
         2'h3:    add = ls <<< 1;
         default: add = 42'sh0;
      endcase
      boost = sat(xs + add);
   endfunction

   function automatic logic [23:0] lp_step(input logic [23:0] x,
                                           input logic [23:0] lp);
      logic signed [41:0] d;
      d = 42'($signed(x)) - 42'($signed(lp));
      lp_step = 24'(42'($signed(lp)) + (d >>> `DVS_LP_SHIFT));
   endfunction

   function automatic logic [23:0] apply(input logic [23:0] x,
                                         input logic [16:0] g);
      logic signed [41:0] p;
      p = 42'($signed(x) * $signed({1'b0, g}));
      apply = sat(p >>> `DVS_GAIN_SHIFT);
   endfunction

   function automatic logic [31:0] wmerge(input logic [31:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0]  strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = d[i*8 +: 8];
         end
      end
      wmerge = r;
   endfunction

   // ****************************************************************
   // State
   // ****************************************************************
   dvs_state_t  s;
   dvs_state_t  next_s;
   logic [10:0] tgt_l;
   logic [10:0] tgt_r;

   // Link chooses which code the right channel follows
   assign tgt_l = target(s.left_volume_code, s.soft_mute_request);
   assign tgt_r = target(s.volume_link ? s.left_volume_code
                                       : s.right_volume_code,
                         s.soft_mute_request);

   always_comb begin
      logic [31:0] ctrl_w;
      logic [31:0] vol_w;
      logic [10:0] inc;
      logic [23:0] bl;
      logic [23:0] br;
      ctrl_w = '0;
      vol_w  = '0;
      inc    = `DVS_STEP_SLOW;
      bl     = '0;
      br     = '0;
      next_s = s;
      // ****************************************************************
      // AXI4-Lite write: address and data accepted in either order
      // ****************************************************************
      if (s.awready && s_axi_awvalid) begin
         next_s.aw_got = 1'b1;
         next_s.awaddr = s_axi_awaddr;
      end
      if (s.wready && s_axi_wvalid) begin
         next_s.w_got = 1'b1;
         next_s.wdata = s_axi_wdata;
         next_s.wstrb = s_axi_wstrb;
      end
      if (s.bvalid && s_axi_bready) begin
         next_s.bvalid = 1'b0;
      end
      if (s.aw_got && s.w_got && !s.bvalid) begin
         ctrl_w = wmerge({26'h0, s.bass_boost_level, 1'b0, s.volume_link,
                          s.ramp_time_select, s.soft_mute_request},
                         s.wdata, s.wstrb);
         vol_w  = wmerge({16'h0, s.right_volume_code, s.left_volume_code},
                         s.wdata, s.wstrb);
         next_s.aw_got = 1'b0;
         next_s.w_got  = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp  = `DVS_RESP_OKAY;
         if (s.awaddr == `DVS_OFS_CTRL) begin
            next_s.soft_mute_request = ctrl_w[`DVS_CTRL_MUTE];
            next_s.ramp_time_select  = ctrl_w[`DVS_CTRL_RSEL];
            next_s.volume_link       = ctrl_w[`DVS_CTRL_LINK];
            next_s.bass_boost_level  =
               ctrl_w[`DVS_CTRL_BST_HI:`DVS_CTRL_BST_LO];
         end else if (s.awaddr == `DVS_OFS_VOL) begin
            next_s.left_volume_code  = vol_w[`DVS_VOL_L_HI:`DVS_VOL_L_LO];
            next_s.right_volume_code = vol_w[`DVS_VOL_R_HI:`DVS_VOL_R_LO];
         end else if (s.awaddr != `DVS_OFS_STATUS) begin
            next_s.bresp = `DVS_RESP_SLVERR;
         end
      end
      // Ready drops while a half is held or a response waits
      next_s.awready = !next_s.aw_got && !next_s.bvalid;
      next_s.wready  = !next_s.w_got && !next_s.bvalid;
      // ****************************************************************
      // AXI4-Lite read
      // ****************************************************************
      if (s.rvalid && s_axi_rready) begin
         next_s.rvalid = 1'b0;
      end
      if (s.arready && s_axi_arvalid) begin
         next_s.rvalid = 1'b1;
         next_s.rdata  = '0;
         next_s.rresp  = `DVS_RESP_OKAY;
         if (s_axi_araddr == `DVS_OFS_CTRL) begin
            next_s.rdata = {26'h0, s.bass_boost_level, 1'b0, s.volume_link,
                            s.ramp_time_select, s.soft_mute_request};
         end else if (s_axi_araddr == `DVS_OFS_VOL) begin
            next_s.rdata = {16'h0, s.right_volume_code, s.left_volume_code};
         end else if (s_axi_araddr == `DVS_OFS_STATUS) begin
            next_s.rdata[`DVS_ST_LL_HI:0] = s.lvl_l;
            next_s.rdata[`DVS_ST_RL_HI:`DVS_ST_RL_LO] = s.lvl_r;
            next_s.rdata[`DVS_ST_RAMP] = (s.lvl_l != tgt_l) ||
                                         (s.lvl_r != tgt_r);
         end else begin
            next_s.rresp = `DVS_RESP_SLVERR;
         end
      end
      next_s.arready = !next_s.rvalid;
      // ****************************************************************
      // Sample path
      // ****************************************************************
      next_s.out_valid = 1'b0;
      if (in_valid) begin
         next_s.phase = 8'(s.phase + 8'h01);
         // fast steps spread the remainder over 256 samples
         if (s.ramp_time_select) begin
            inc = (s.phase < `DVS_FAST_EXTRA) ? `DVS_STEP_FASTX
                                              : `DVS_STEP_FAST;
         end
         // ramp toward mute or back from where it stands
         next_s.lvl_l = ramp(s.lvl_l, tgt_l, inc);
         next_s.lvl_r = ramp(s.lvl_r, tgt_r, inc);
         // lift lows, clip at full scale
         bl = boost(in_sample.left, s.lp_l, s.bass_boost_level);
         br = boost(in_sample.right, s.lp_r, s.bass_boost_level);
         next_s.lp_l = lp_step(in_sample.left, s.lp_l);
         next_s.lp_r = lp_step(in_sample.right, s.lp_r);
         next_s.out_sample.left  = apply(bl, gain_of(s.lvl_l));
         next_s.out_sample.right = apply(br, gain_of(s.lvl_r));
         next_s.out_valid = 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s <= '0;
         s.left_volume_code  <= `DVS_RST_CODE;
         s.right_volume_code <= `DVS_RST_CODE;
         s.bass_boost_level  <= `DVS_RST_BOOST;
         s.lvl_l <= `DVS_LVL_UNITY;
         s.lvl_r <= `DVS_LVL_UNITY;
      end else begin
         s <= next_s;
      end
   end

   assign s_axi_awready = s.awready;
   assign s_axi_wready  = s.wready;
   assign s_axi_bvalid  = s.bvalid;
   assign s_axi_bresp   = s.bresp;
   assign s_axi_arready = s.arready;
   assign s_axi_rvalid  = s.rvalid;
   assign s_axi_rdata   = s.rdata;
   assign s_axi_rresp   = s.rresp;
   assign out_valid     = s.out_valid;
   assign out_sample    = s.out_sample;

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   AST_BOOST_OFF_UNITY: assert property (
      in_valid && s.bass_boost_level == 2'h0 && s.lvl_l == `DVS_LVL_UNITY
      |=> out_valid && out_sample.left == $past(in_sample.left))
      else $error("Unity path altered the sample");
   AST_NO_WRAP: assert property (
      in_valid && s.lvl_l == 11'h000 && !in_sample.left[23]
      && !s.lp_l[23] |=> !out_sample.left[23])
      else $error("Positive sample wrapped negative");
   AST_MUTE_ZERO: assert property (
      in_valid && s.lvl_l == `DVS_LVL_MAX |=> out_sample.left == 24'h000000)
      else $error("Mute level left signal through");
   AST_CODE_MAP: assert property (
      !s.soft_mute_request && s.left_volume_code != `DVS_CODE_MUTE
      |-> tgt_l == {1'b0, s.left_volume_code, 2'b00})
      else $error("Volume code decoded wrongly");
   AST_LINK: assert property (
      s.volume_link |-> tgt_r == tgt_l)
      else $error("Linked right channel not following left");
   AST_SPLIT: assert property (
      !s.volume_link && !s.soft_mute_request
      && s.right_volume_code != `DVS_CODE_MUTE
      |-> tgt_r == {1'b0, s.right_volume_code, 2'b00})
      else $error("Right channel not using its own code");
   AST_SLOW_STEP: assert property (
      in_valid && !s.ramp_time_select && s.lvl_l < tgt_l
      |=> s.lvl_l == $past(s.lvl_l) + 11'h001)
      else $error("Slow ramp step is not one level");
   AST_SOFT_MUTE: assert property (
      s.soft_mute_request |-> tgt_l == `DVS_LVL_MAX && tgt_r == `DVS_LVL_MAX)
      else $error("Soft mute not aiming at silence");
   AST_RETURN: assert property (
      in_valid && !s.soft_mute_request && s.lvl_l > tgt_l
      |=> s.lvl_l < $past(s.lvl_l))
      else $error("Released mute did not turn back");
   AST_HOLD: assert property (
      !in_valid |=> $stable(s.lvl_l) && !out_valid)
      else $error("Ramp moved without a sample");
   AST_BHOLD: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("Write response dropped early");
endmodule
`default_nettype wire

// >>> tb/dvs_dac_model.sv
// Stereo converter stand-in that keeps the latest processed sample
`timescale 1ns/100ps
`default_nettype none
module dvs_dac_model
   import dvs_pkg::*;
(
   input  wire logic      aclk,       // Sample clock domain
   input  wire logic      aresetn,    // Sync reset, active low
   input  wire logic      out_valid,  // Sample strobe from the block
   input  wire dvs_pair_t out_sample, // Processed stereo sample
   output var dvs_pair_t  last,       // Latest sample taken
   output logic [15:0]    n_taken     // Samples taken since reset
);
   // Latches only on the strobe, so a late or doubled strobe shows as a count
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         last    <= '0;
         n_taken <= '0;
      end else if (out_valid) begin
         last    <= out_sample;
         n_taken <= n_taken + 16'h0001;
      end
   end
endmodule
`default_nettype wire

// >>> tb/dac_volume_softmute_boost_test.sv
// Self-checking bench of the playback volume, soft mute and bass boost block
`timescale 1ns/100ps
`default_nettype none
`include "dvs_cfg.svh"
module dac_volume_softmute_boost_test;
   import dvs_pkg::*;
   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0]  wstrb;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp;
   logic        in_valid, out_valid;
   dvs_pair_t   in_sample, out_sample, last;
   logic [15:0] n_out;
   logic [31:0] seed;
   int          fails, n_checks, n_sent;

   always #20 aclk = ~aclk;

   dvs_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .in_valid(in_valid),
      .in_sample(in_sample), .out_valid(out_valid), .out_sample(out_sample));
   dvs_dac_model dac_u (.aclk(aclk), .aresetn(aresetn),
      .out_valid(out_valid), .out_sample(out_sample), .last(last),
      .n_taken(n_out));

   // ************************************************************
   // Helpers
   // ************************************************************
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // Expected status word: ramp flag, right level, left level
   function automatic logic [31:0] st(input logic rmp,
                                      input logic [10:0] rl, ll);
      return {rmp, 4'h0, rl, 5'h00, ll};
   endfunction

   task automatic chk_reg(input logic [31:0] got, exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_smp(input dvs_pair_t got, exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic close_out;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // ************************************************************
   // Bus and sample drivers
   // ************************************************************
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                         output logic [1:0] r);
      int t;
      logic aw, w;
      aw = 0;
      w  = 0;
      t  = 0;
      @(posedge aclk);
      awaddr  <= a;
      awvalid <= 1'b1;
      wdata   <= d;
      wstrb   <= 4'hF;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      while (!(aw && w) && t < 100) begin
         @(posedge aclk);
         t++;
         if (!aw && awready === 1'b1) begin
            aw = 1;
            awvalid <= 1'b0;
         end
         if (!w && wready === 1'b1) begin
            w = 1;
            wvalid <= 1'b0;
         end
      end
      do begin
         @(posedge aclk);
         t++;
      end while (bvalid !== 1'b1 && t < 200);
      r = bresp;
      bready <= 1'b0;
      if (t >= 200) fails++;
   endtask

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                         output logic [1:0] r);
      int t;
      t = 0;
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do begin
         @(posedge aclk);
         t++;
      end while (arready !== 1'b1 && t < 100);
      arvalid <= 1'b0;
      do begin
         @(posedge aclk);
         t++;
      end while (rvalid !== 1'b1 && t < 200);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      if (t >= 200) fails++;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r;
      axi_wr(a, d, r);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] d;
      logic [1:0]  r;
      axi_rd(a, d, r);
      chk_reg(d, exp);
   endtask

   // One sample in; the converter stand-in holds the answer afterwards
   task automatic send(input dvs_pair_t v);
      @(posedge aclk);
      in_valid  <= 1'b1;
      in_sample <= v;
      @(posedge aclk);
      in_valid  <= 1'b0;
      @(posedge aclk);
      #1;
      n_sent++;
   endtask

   task automatic sendr(input int n);
      repeat (n) begin
         seed = lfsr(seed);
         send({seed[23:0], seed[31:8]});
      end
   endtask

   // Feeds samples until the ramp flag drops; bounded
   task automatic settle(output int n);
      logic [31:0] d;
      logic [1:0]  r;
      n = 0;
      do begin
         sendr(1);
         n++;
         axi_rd(`DVS_OFS_STATUS, d, r);
      end while (d[31] !== 1'b0 && n < 400);
   endtask

   // ************************************************************
   // Scenarios
   // ************************************************************
   initial begin
      int n;
      logic [31:0] d;
      logic [1:0]  r;
      dvs_pair_t   v;
      logic signed [23:0] prev;
      aclk = 0; aresetn = 0; awvalid = 0; wvalid = 0; bready = 0;
      arvalid = 0; rready = 0; awaddr = 0; araddr = 0; wdata = 0;
      wstrb = 0; in_valid = 0; in_sample = '0; seed = 32'h6303;
      fails = 0; n_checks = 0; n_sent = 0; prev = 0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd_chk(`DVS_OFS_CTRL, 32'h0000_0000);
      rd_chk(`DVS_OFS_VOL, 32'h0000_1818);
      rd_chk(`DVS_OFS_STATUS, st(0, 11'h060, 11'h060));
      axi_rd(8'h0C, d, r);
      chk_reg({30'h0, r}, 32'h0000_0002);
      axi_wr(8'h0C, 32'h0000_0003, r);
      chk_reg({30'h0, r}, 32'h0000_0002);
      axi_wr(`DVS_OFS_STATUS, 32'hFFFF_FFFF, r);
      chk_reg({30'h0, r}, 32'h0000_0000);
      $display("test registers done");
      repeat (8) begin
         seed = lfsr(seed);
         v = {seed[23:0], seed[31:8]};
         send(v);
         chk_smp(last, v);
      end
      wr(`DVS_OFS_VOL, 32'h0000_1C1C);
      sendr(10);
      rd_chk(`DVS_OFS_STATUS, st(1, 11'h06A, 11'h06A));
      sendr(6);
      rd_chk(`DVS_OFS_STATUS, st(0, 11'h070, 11'h070));
      wr(`DVS_OFS_CTRL, 32'h0000_0004);
      wr(`DVS_OFS_VOL, 32'h0000_001A);
      sendr(8);
      rd_chk(`DVS_OFS_STATUS, st(0, 11'h068, 11'h068));
      wr(`DVS_OFS_CTRL, 32'h0000_0000);
      sendr(8);
      rd_chk(`DVS_OFS_STATUS, st(1, 11'h060, 11'h068));
      $display("test slow ramp and link done");
      wr(`DVS_OFS_CTRL, 32'h0000_0002);
      wr(`DVS_OFS_VOL, 32'h0000_FFFF);
      settle(n);
      chk_reg({31'h0, n >= 193 && n <= 256}, 32'h1);
      rd_chk(`DVS_OFS_STATUS, st(0, 11'h425, 11'h425));
      sendr(1);
      chk_smp(last, '0);
      wr(`DVS_OFS_VOL, 32'h0000_1818);
      settle(n);
      wr(`DVS_OFS_CTRL, 32'h0000_0003);
      settle(n);
      rd_chk(`DVS_OFS_STATUS, st(0, 11'h425, 11'h425));
      sendr(1);
      chk_smp(last, '0);
      wr(`DVS_OFS_CTRL, 32'h0000_0002);
      settle(n);
      rd_chk(`DVS_OFS_STATUS, st(0, 11'h060, 11'h060));
      wr(`DVS_OFS_CTRL, 32'h0000_0001);
      sendr(20);
      rd_chk(`DVS_OFS_STATUS, st(1, 11'h074, 11'h074));
      wr(`DVS_OFS_CTRL, 32'h0000_0000);
      sendr(5);
      rd_chk(`DVS_OFS_STATUS, st(1, 11'h06F, 11'h06F));
      settle(n);
      $display("test fast ramp and soft mute done");
      v = {24'h100000, 24'h100000};
      for (int b = 0; b < 4; b++) begin
         wr(`DVS_OFS_CTRL, {26'h0, b[1:0], 4'h0});
         repeat (64) send(v);
         if (b == 0)
            chk_smp(last, v);
         else
            chk_reg({31'h0, $signed(last.left) > prev}, 32'h1);
         prev = $signed(last.left);
      end
      v = {24'h7FFFFF, 24'h7FFFFF};
      repeat (64) send(v);
      chk_smp(last, v);
      v = {24'h800000, 24'h800000};
      repeat (64) send(v);
      chk_smp(last, v);
      // Top code: gain of four, so large samples must clip, not wrap
      wr(`DVS_OFS_CTRL, 32'h0000_0000);
      wr(`DVS_OFS_VOL, 32'h0000_0000);
      settle(n);
      rd_chk(`DVS_OFS_STATUS, st(0, 11'h000, 11'h000));
      v = {24'h001000, 24'h001000};
      send(v);
      chk_smp(last, {24'h004000, 24'h004000});
      v = {24'h400000, 24'hC00000};
      send(v);
      chk_smp(last, {24'h7FFFFF, 24'h800000});
      chk_reg({16'h0, n_out}, n_sent[31:0]);
      $display("test bass boost done");
      close_out;
   end

   initial begin
      repeat (60000) @(posedge aclk);
      fails++;
      close_out;
   end
endmodule
`default_nettype wire
